// File: logic/vcd_pkg.sv
// Constants of the verify command decoder.
package vcd_pkg;

    // ----
    // Command identification.
    // ----
    localparam logic [7:0] OP_VERIFY12 = 8'hAF;
    localparam logic [7:0] OP_VERIFY16 = 8'h8F;
    localparam logic [7:0] OP_VARLEN = 8'h7F;
    localparam logic [15:0] SA_VERIFY32 = 16'h000A;
    localparam logic [7:0] ADD_LEN_32 = 8'h18;
    localparam int CDB_BYTES = 32;

    // ----
    // Protection and compare selections.
    // ----
    localparam logic [2:0] PTYPE_REQUIRED = 3'h1;
    localparam logic [2:0] PROT_LAST_VALID = 3'h4;
    localparam logic [1:0] BC_MEDIA = 2'h0;
    localparam logic [1:0] BC_EACH = 2'h1;
    localparam logic [1:0] BC_UNDEF = 2'h2;
    localparam logic [1:0] BC_SINGLE = 2'h3;

    // Which form was decoded, one-hot.
    localparam logic [2:0] FORM_NONE = 3'h0;
    localparam logic [2:0] FORM_12 = 3'h1;
    localparam logic [2:0] FORM_16 = 3'h2;
    localparam logic [2:0] FORM_32 = 3'h4;

    // ----
    // Sense reporting.
    // ----
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [3:0] SK_ABORTED = 4'hB;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
    localparam logic [7:0] ASC_PI_FAIL = 8'h10;
    localparam logic [7:0] ASCQ_GUARD = 8'h01;
    localparam logic [7:0] ASCQ_APP = 8'h02;
    localparam logic [7:0] ASCQ_REF = 8'h03;

    // ----
    // Register byte offsets and field positions.
    // ----
    localparam logic [11:0] A_CDB_LAST = 12'h01C;
    localparam logic [11:0] A_CONFIG = 12'h020;
    localparam logic [11:0] A_CONTROL = 12'h024;
    localparam logic [11:0] A_STATUS = 12'h028;
    localparam logic [11:0] A_FIELDS = 12'h02C;
    localparam logic [11:0] A_LBA_LO = 12'h030;
    localparam logic [11:0] A_LBA_HI = 12'h034;
    localparam logic [11:0] A_LENGTH = 12'h038;
    localparam logic [11:0] A_REF_TAG = 12'h03C;
    localparam logic [11:0] A_APP_TAG = 12'h040;
    localparam logic [11:0] A_PI_REF = 12'h044;
    localparam logic [11:0] A_PI_APP = 12'h048;
    localparam int CFG_PROTECTION_ENABLED_BIT = 0;
    localparam int CFG_PTYPE_LSB = 1;
    localparam int CFG_ATO_BIT = 4;
    localparam int CTL_DECODE_BIT = 0;
    localparam int CTL_PICHK_BIT = 1;
    localparam int PI_GUARD_OK_BIT = 16;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// File: logic/vcd_dec_if.sv
// Carrier between the register front end and the command field decoder.
`timescale 1ns/1ps
interface vcd_dec_if;
    logic [7:0] cdb [vcd_pkg::CDB_BYTES]; // Command block, byte 0 first.
    logic protection_enabled;
    logic [2:0] p_type;
    logic app_tag_owner;
    logic [2:0] form;
    logic chk_cond;
    logic [3:0] sense_key;
    logic [7:0] asc;
    logic [2:0] verify_protect_select;
    logic dpo, fua;
    logic [1:0] byte_compare_select;
    logic [1:0] vendor_unique_bits;
    logic flag, link;
    logic [63:0] lba;
    logic [31:0] length;
    logic [31:0] ref_tag;
    logic [15:0] app_tag;
    logic [15:0] app_mask;
    logic chk_guard, chk_app, chk_ref, no_xfer;

    modport front (output cdb, protection_enabled, p_type, app_tag_owner,
        input form, chk_cond, sense_key, asc, verify_protect_select, dpo, fua,
        byte_compare_select, vendor_unique_bits, flag, link, lba, length,
        ref_tag, app_tag, app_mask, chk_guard, chk_app, chk_ref, no_xfer);
    modport dec (input cdb, protection_enabled, p_type, app_tag_owner,
        output form, chk_cond, sense_key, asc, verify_protect_select, dpo, fua,
        byte_compare_select, vendor_unique_bits, flag, link, lba, length,
        ref_tag, app_tag, app_mask, chk_guard, chk_app, chk_ref, no_xfer);
endinterface

// File: logic/vcd_field_decoder.sv
// Combinational field extraction and legality checks for the verify command blocks.
`timescale 1ns/1ps
module vcd_field_decoder (
    vcd_dec_if.dec d
);
    logic [255:0] flat; // Byte 0 on top, so fields read MSB first.
    logic [7:0] b1; // Byte holding the selectors.
    logic [7:0] ctl; // Control byte: last byte of the short forms, byte 1 of the 32-byte form.

    // Four bytes from byte s, MSB first.
    function automatic logic [31:0] be32(input logic [255:0] v, input int s);
        be32 = v[255 - 8 * s -: 32];
    endfunction

    always_comb begin
        for (int i = 0; i < vcd_pkg::CDB_BYTES; i++) begin
            flat[255 - 8 * i -: 8] = d.cdb[i];
        end
    end

    // ----
    // Extraction and checks, earliest failure reported.
    // ----
    always_comb begin
        b1 = 8'h00;
        ctl = 8'h00;
        d.form = vcd_pkg::FORM_NONE;
        d.fua = 1'b0;
        d.lba = 64'h0;
        d.length = 32'h0;
        d.ref_tag = 32'h0;
        d.app_tag = 16'h0;
        d.app_mask = 16'h0;
        case (d.cdb[0])
            vcd_pkg::OP_VERIFY12: begin // (R1) (R3)
                d.form = vcd_pkg::FORM_12;
                b1 = d.cdb[1];
                d.fua = b1[3]; // (R2)
                d.lba = {32'h0, be32(flat, 2)};
                d.length = be32(flat, 6);
                ctl = d.cdb[11];
            end
            vcd_pkg::OP_VERIFY16: begin // (R4) (R6)
                d.form = vcd_pkg::FORM_16;
                b1 = d.cdb[1];
                d.fua = 1'b0; // (R5)
                d.lba = {be32(flat, 2), be32(flat, 6)};
                d.length = be32(flat, 10);
                ctl = d.cdb[15];
            end
            vcd_pkg::OP_VARLEN: begin
                if ({d.cdb[8], d.cdb[9]} == vcd_pkg::SA_VERIFY32) begin // (R8)
                    d.form = vcd_pkg::FORM_32;
                    b1 = d.cdb[10]; // (R10)
                    d.lba = {be32(flat, 12), be32(flat, 16)};
                    d.ref_tag = be32(flat, 20); // (R12)
                    // Tag and mask mean nothing unless the owner setting is one.
                    if (d.app_tag_owner) begin // (R13) (R14)
                        d.app_tag = {d.cdb[24], d.cdb[25]};
                        d.app_mask = {d.cdb[26], d.cdb[27]};
                    end
                    d.length = be32(flat, 28);
                    ctl = d.cdb[1];
                end
            end
            default: begin
                d.form = vcd_pkg::FORM_NONE;
            end
        endcase
        d.verify_protect_select = b1[7:5];
        d.dpo = b1[4];
        d.byte_compare_select = b1[2:1]; // (R16)
        d.vendor_unique_bits = ctl[7:6]; // (R20)
        d.flag = ctl[1];
        d.link = ctl[0];
        d.no_xfer = (d.length == 32'h0); // (R18)
        d.chk_cond = 1'b1;
        d.sense_key = vcd_pkg::SK_ILLEGAL;
        d.asc = vcd_pkg::ASC_BAD_FIELD;
        if (d.form == vcd_pkg::FORM_NONE) begin
            d.asc = vcd_pkg::ASC_BAD_OPCODE;
        end else if (d.form == vcd_pkg::FORM_32 && !(d.protection_enabled
                && d.p_type == vcd_pkg::PTYPE_REQUIRED)) begin
            d.asc = vcd_pkg::ASC_BAD_OPCODE; // (R11)
        end else if (d.form == vcd_pkg::FORM_32 && d.cdb[7] != vcd_pkg::ADD_LEN_32) begin
            d.asc = vcd_pkg::ASC_BAD_FIELD; // (R7)
        end else if (d.verify_protect_select > vcd_pkg::PROT_LAST_VALID
                || (d.verify_protect_select != 3'h0 && !d.protection_enabled)) begin
            d.asc = vcd_pkg::ASC_BAD_FIELD; // (R17)
        end else if (d.byte_compare_select == vcd_pkg::BC_UNDEF) begin
            d.asc = vcd_pkg::ASC_BAD_FIELD;
        end else begin
            d.chk_cond = 1'b0;
            d.sense_key = vcd_pkg::SK_NONE;
            d.asc = vcd_pkg::ASC_NONE;
        end
    end

    // ----
    // Which protection fields each block is checked on.
    // ----
    always_comb begin
        d.chk_guard = 1'b0;
        d.chk_app = 1'b0;
        d.chk_ref = 1'b0;
        if (d.protection_enabled) begin // (R15)
            case (d.verify_protect_select)
                3'h0, 3'h1: begin
                    d.chk_guard = 1'b1;
                    d.chk_app = 1'b1;
                    d.chk_ref = 1'b1;
                end
                3'h2: begin
                    d.chk_app = 1'b1;
                    d.chk_ref = 1'b1;
                end
                3'h4: begin
                    d.chk_guard = 1'b1;
                end
                default: begin
                    d.chk_guard = 1'b0;
                end
            endcase
        end
        // App tag checks: long form, owning initiator only.
        d.chk_app = d.chk_app && d.form == vcd_pkg::FORM_32 && d.app_tag_owner;
    end
endmodule // vcd_field_decoder

// File: logic/vcd_pi_check.sv
// Compares the first block's stored protection information against the expected values.
`timescale 1ns/1ps
module vcd_pi_check (
    input wire logic chk_guard,
    input wire logic chk_app,
    input wire logic chk_ref,
    input wire logic guard_ok,
    input wire logic [31:0] exp_ref,
    input wire logic [31:0] got_ref,
    input wire logic [15:0] exp_app,
    input wire logic [15:0] app_mask,
    input wire logic [15:0] got_app,
    output logic fail,
    output logic [7:0] ascq
);
    // Guard first, then application tag, then reference tag.
    always_comb begin
        fail = 1'b1;
        ascq = vcd_pkg::ASCQ_GUARD;
        if (chk_guard && !guard_ok) begin
            ascq = vcd_pkg::ASCQ_GUARD;
        end else if (chk_app && ((exp_app ^ got_app) & app_mask) != 16'h0) begin
            ascq = vcd_pkg::ASCQ_APP; // (R13)
        end else if (chk_ref && exp_ref != got_ref) begin
            ascq = vcd_pkg::ASCQ_REF; // (R12)
        end else begin
            fail = 1'b0;
            ascq = 8'h00;
        end
    end
endmodule // vcd_pi_check

// File: logic/vcd_verify_decoder.sv
// Top of the verify command decoder.
//
// What this block does, and what the initiator owes it
// (R1) Opcode AFh: 12-byte form, address and count.
// (R2) 12-byte byte 1: protect, priority, force, compare.
// (R3) 12-byte fields mean the same as 10-byte.
// (R4) Opcode 8Fh: 16-byte form, 64-bit address.
// (R5) 16-byte byte 1: force-access bit reads zero.
// (R6) 16-byte fields mean the same as 10-byte.
// (R7) 32-byte form needs additional length 18h.
// (R8) Dispatch 32-byte only on 7Fh with 000Ah.
// (R9) Initiator zeroes group number in byte 6.
// (R10) 32-byte field positions: selectors, address, tag, count.
// (R11) 32-byte needs protection type 001b enabled.
// (R12) Reference tag checked on first block.
// (R13) Mask bits enable application tag bit compares.
// (R14) Owner zero: tag and mask ignored.
// (R15) Blocks carry user data plus selected protection.
// (R16) Compare selector: media, each, single, 10b undefined.
// (R17) Reserved or unsupported protect: invalid field.
// (R18) Zero length moves nothing, no error.
// (R19) Protection failure: aborted command, field code.
// (R20) Short forms: vendor, flag, link from last byte.
// (R21) Initiator zeroes all reserved fields.
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
module vcd_verify_decoder (
    input wire logic clock,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic verify_start
);
    // ----
    // Storage and wiring.
    // ----
    vcd_dec_if dif (); // Link to the field decoder.
    logic [7:0] cdb [vcd_pkg::CDB_BYTES]; // Command block.
    logic protection_enabled; // Protection on.
    logic [2:0] p_type; // Protection type.
    logic app_tag_owner; // Tag owner setting.
    logic [31:0] pi_ref; // First block's ref tag.
    logic [15:0] pi_app; // First block's app tag.
    logic pi_guard_ok; // First block's guard good.
    logic ph_wr; // Write data phase pending.
    logic ph_rd; // Read wait cycle pending.
    logic [11:0] ph_addr; // Address of that phase.
    logic ph_word; // That phase is a whole word.
    logic accept; // Address phase taken this cycle.
    logic wr_now; // Word write completes this edge.
    logic do_decode; // Control write asks for a decode.
    logic do_pichk; // Control write asks for a tag check.
    logic pi_fail; // Tag check failed.
    logic [7:0] pi_ascq; // Failing field code.
    logic [31:0] rd_mux; // Read value.
    // Results, held until the next decode or tag check.
    logic decoded;
    logic res_cond;
    logic [3:0] res_key;
    logic [7:0] res_asc;
    logic [7:0] res_ascq;
    logic [2:0] res_form;
    logic res_noxfer;
    logic res_pifail;
    logic [13:0] res_fields;
    logic [63:0] res_lba;
    logic [31:0] res_len;
    logic [31:0] res_ref;
    logic [31:0] res_app;

    // ----
    // Decoder and tag comparator.
    // ----
    // Decode is combinational on the stored block,
    // so the control write's own edge takes results.
    assign dif.cdb = cdb;
    assign dif.protection_enabled = protection_enabled;
    assign dif.p_type = p_type;
    assign dif.app_tag_owner = app_tag_owner;

    vcd_field_decoder u_dec (
        .d(dif)
    );

    vcd_pi_check u_pi (
        .chk_guard(dif.chk_guard),
        .chk_app(dif.chk_app),
        .chk_ref(dif.chk_ref),
        .guard_ok(pi_guard_ok),
        .exp_ref(dif.ref_tag),
        .got_ref(pi_ref),
        .exp_app(dif.app_tag),
        .app_mask(dif.app_mask),
        .got_app(pi_app),
        .fail(pi_fail),
        .ascq(pi_ascq)
    );

    // ----
    // Bus phase tracking.
    // ----
    assign accept = hsel && htrans[1]
        && hready;
    // Narrow writes are answered OKAY but change nothing.
    assign wr_now = ph_wr && ph_word;
    assign do_decode = wr_now
        && ph_addr == vcd_pkg::A_CONTROL
        && hwdata[vcd_pkg::CTL_DECODE_BIT];
    assign do_pichk = wr_now && ph_addr == vcd_pkg::A_CONTROL
        && hwdata[vcd_pkg::CTL_PICHK_BIT];

    // Reads get one wait cycle, so read data
    // sees a write that ended at the same edge.
    always_ff @(posedge clock) begin
        if (srst) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 12'h000;
            ph_word <= 1'b0;
            hreadyout <= 1'b1;
        end else if (ph_rd) begin
            // The wait cycle ends; read data loads now.
            ph_rd <= 1'b0;
            ph_wr <= 1'b0;
            hreadyout <= 1'b1;
        end else begin
            ph_wr <= accept && hwrite;
            ph_rd <= accept && !hwrite;
            // Wait in a read's data phase.
            hreadyout <= !(accept && !hwrite);
            if (accept) begin
                ph_addr <= haddr[11:0];
                ph_word <= hsize == vcd_pkg::HSIZE_WORD
                    && haddr[1:0] == 2'h0;
            end
        end
    end

    // Read data loads in the wait cycle.
    always_ff @(posedge clock) begin
        if (srst) begin
            hrdata <= 32'h0;
        end else if (ph_rd) begin
            hrdata <= rd_mux;
        end
    end

    // Every transfer ends OKAY.
    always_ff @(posedge clock) begin
        hresp <= 1'b0;
    end

    // ----
    // Software-written registers.
    // ----
    // Command block words: byte 4n sits in the low lane of word n.
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < vcd_pkg::CDB_BYTES; i++) begin
                cdb[i] <= 8'h00;
            end
        end else if (wr_now
                && ph_addr <= vcd_pkg::A_CDB_LAST) begin
            for (int k = 0; k < 4; k++) begin
                cdb[{ph_addr[4:2], 2'(k)}] <= hwdata[8 * k +: 8];
            end
        end
    end

    // Medium format, used by the legality checks.
    always_ff @(posedge clock) begin
        if (srst) begin
            protection_enabled <= 1'b0;
            p_type <= 3'h0;
            app_tag_owner <= 1'b0;
        end else if (wr_now
                && ph_addr == vcd_pkg::A_CONFIG) begin
            protection_enabled <= hwdata[vcd_pkg::CFG_PROTECTION_ENABLED_BIT];
            p_type <= hwdata[vcd_pkg::CFG_PTYPE_LSB +: 3];
            app_tag_owner <= hwdata[vcd_pkg::CFG_ATO_BIT];
        end
    end

    // First block's protection information from the medium.
    always_ff @(posedge clock) begin
        if (srst) begin
            pi_ref <= 32'h0;
            pi_app <= 16'h0;
            pi_guard_ok <= 1'b0;
        end else if (wr_now
                && ph_addr == vcd_pkg::A_PI_REF) begin
            pi_ref <= hwdata;
        end else if (wr_now
                && ph_addr == vcd_pkg::A_PI_APP) begin
            pi_app <= hwdata[15:0];
            pi_guard_ok <= hwdata[vcd_pkg::PI_GUARD_OK_BIT];
        end
    end

    // ----
    // Result capture.
    // ----
    // A decode refreshes status; a failed tag check
    // on a legal command turns it into an abort.
    always_ff @(posedge clock) begin
        if (srst) begin
            decoded <= 1'b0;
            res_cond <= 1'b0;
            res_key <= vcd_pkg::SK_NONE;
            res_asc <= vcd_pkg::ASC_NONE;
            res_ascq <= 8'h00;
            res_pifail <= 1'b0;
        end else if (do_decode || do_pichk) begin
            decoded <= 1'b1;
            res_cond <= dif.chk_cond;
            res_key <= dif.sense_key;
            res_asc <= dif.asc;
            res_ascq <= 8'h00;
            res_pifail <= 1'b0;
            if (do_pichk && !dif.chk_cond && pi_fail) begin
                res_cond <= 1'b1; // (R19)
                res_key <= vcd_pkg::SK_ABORTED;
                res_asc <= vcd_pkg::ASC_PI_FAIL;
                res_ascq <= pi_ascq;
                res_pifail <= 1'b1;
            end
        end
    end

    // Decoded fields, held for software.
    always_ff @(posedge clock) begin
        if (srst) begin
            res_form <= vcd_pkg::FORM_NONE;
            res_noxfer <= 1'b0;
            res_fields <= 14'h0;
            res_lba <= 64'h0;
            res_len <= 32'h0;
            res_ref <= 32'h0;
            res_app <= 32'h0;
        end else if (do_decode || do_pichk) begin
            res_form <= dif.form;
            res_noxfer <= dif.no_xfer; // (R18)
            res_fields <= {dif.chk_ref, dif.chk_app, dif.chk_guard,
                dif.link, dif.flag, dif.vendor_unique_bits,
                dif.byte_compare_select, dif.fua, dif.dpo,
                dif.verify_protect_select}; // (R15) (R20)
            res_lba <= dif.lba;
            res_len <= dif.length;
            res_ref <= dif.ref_tag;
            res_app <= {dif.app_mask, dif.app_tag}; // (R14)
        end
    end

    // Start only a legal command with blocks;
    // a zero length ends good, nothing moved.
    always_ff @(posedge clock) begin
        if (srst) begin
            verify_start <= 1'b0;
        end else begin
            verify_start <= do_decode && !dif.chk_cond
                && !dif.no_xfer
                && !(do_pichk && pi_fail); // (R18)
        end
    end

    // ----
    // Read multiplexer; unmapped offsets read zero.
    // ----
    always_comb begin
        case (ph_addr)
            vcd_pkg::A_CONFIG: rd_mux = {27'h0, app_tag_owner, p_type,
                protection_enabled};
            vcd_pkg::A_STATUS: rd_mux = {3'h0, res_pifail, res_noxfer,
                res_form, res_ascq, res_asc, res_key,
                2'h0, res_cond, decoded};
            vcd_pkg::A_FIELDS: rd_mux = {18'h0, res_fields};
            vcd_pkg::A_LBA_LO: rd_mux = res_lba[31:0];
            vcd_pkg::A_LBA_HI: rd_mux = res_lba[63:32];
            vcd_pkg::A_LENGTH: rd_mux = res_len;
            vcd_pkg::A_REF_TAG: rd_mux = res_ref;
            vcd_pkg::A_APP_TAG: rd_mux = res_app;
            vcd_pkg::A_PI_REF: rd_mux = pi_ref;
            vcd_pkg::A_PI_APP: rd_mux = {15'h0, pi_guard_ok, pi_app};
            default: begin
                // Command block words read back in lane order.
                if (ph_addr <= vcd_pkg::A_CDB_LAST && ph_addr[1:0] == 2'h0) begin
                    rd_mux = {cdb[{ph_addr[4:2], 2'h3}], cdb[{ph_addr[4:2], 2'h2}],
                        cdb[{ph_addr[4:2], 2'h1}], cdb[{ph_addr[4:2], 2'h0}]};
                end else begin
                    rd_mux = 32'h0;
                end
            end
        endcase
    end
endmodule // vcd_verify_decoder

// File: verification/vcd_initiator.sv
// Initiator model that builds verify command blocks byte by byte.
`timescale 1ns/1ps
module vcd_initiator;
    logic [7:0] cdb [vcd_pkg::CDB_BYTES]; // Block being built, byte 0 first.
    // Places n bytes of v, most significant byte first.
    task put(input int p, input logic [63:0] v, input int n);
        for (int i = 0; i < n; i++) cdb[p + i] = v[8 * (n - 1 - i) +: 8];
    endtask
    task build(input logic [1:0] f, input logic [63:0] lba, input logic [31:0] len,
        input logic [7:0] b1, input logic [7:0] c, input logic [63:0] tg, input logic [7:0] xl);
        foreach (cdb[i]) cdb[i] = 8'h00;
        if (f != 2'h2) begin
            put(0, {(f == 2'h0) ? vcd_pkg::OP_VERIFY12 : vcd_pkg::OP_VERIFY16, b1}, 2);
            put(2, lba, (f == 2'h0) ? 4 : 8);
            put((f == 2'h0) ? 6 : 10, len, 4);
            cdb[(f == 2'h0) ? 11 : 15] = c;
        end else begin
            put(0, {vcd_pkg::OP_VARLEN, c}, 2);
            put(7, {xl, vcd_pkg::SA_VERIFY32, b1}, 4);
            put(12, lba, 8);
            put(20, tg, 8);
            put(28, len, 4);
        end
    endtask
endmodule // vcd_initiator

// File: verification/vcd_verify_decoder_asserts.sv
// Checker of the decoder's bus answers and start pulse.
`timescale 1ns/1ps
module vcd_verify_decoder_asserts (
    input wire logic clock,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic verify_start
);
    wire rd = hsel && htrans[1] && hready && !hwrite; // Read taken at this edge.
    wire wr = hsel && htrans[1] && hready && hwrite; // Write taken at this edge.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_wait: assert property (rd |=> s_one_wait) else $error("read wait wrong");
    a_write_fast: assert property (wr |=> hreadyout) else $error("write stalled");
    a_wait_cause: assert property (!hreadyout |-> $past(rd)) else $error("stray wait");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_rdata_hold: assert property (!$rose(hreadyout) && !$past(srst) |-> $stable(hrdata))
        else $error("read data moved");
    a_start_pulse: assert property (verify_start |=> !verify_start) else $error("long start");
    a_start_cause: assert property (verify_start |-> $past(wr, 2) &&
        $past(haddr[11:0], 2) == vcd_pkg::A_CONTROL) else $error("start without control");
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> hreadyout && !verify_start &&
        hrdata == 32'h0) else $error("reset state wrong");
endmodule // vcd_verify_decoder_asserts

// File: verification/vcd_verify_decoder_tb.sv
// Self-checking bench of the verify command decoder over AHB-Lite.
`timescale 1ns/1ps
module vcd_verify_decoder_tb;
    logic clock, srst, hsel, hwrite, hreadyout, hresp, verify_start;
    logic [31:0] haddr, hwdata, hrdata, q, len, cfg, r;
    logic [1:0] htrans, f;
    logic [2:0] hsize;
    logic [7:0] b1, c, xl;
    logic [63:0] lba, tg;
    logic [39:0] t;
    logic [1:0] bcs [3] = '{vcd_pkg::BC_MEDIA, vcd_pkg::BC_EACH, vcd_pkg::BC_SINGLE};
    logic [39:0] errs [7] = '{40'h0200111820, 40'h0200131724, 40'h00A0031824, 40'h00C0031824,
        40'h00E0031824, 40'h0020001824, 40'h0104001824}; // Form, byte, config, length, code.
    logic [39:0] pis [4] = '{40'h1301A5A503, 40'h1300A4A500, 40'h1300A5A402, 40'h0300A5A400};
    int bad_count, n_compared, starts, s0;
    vcd_initiator init();
    vcd_verify_decoder dut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .verify_start(verify_start));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (verify_start === 1'b1) starts <= starts + 1;
    initial begin
        #200000 bad_count++;
        finish_test();
    end
    task finish_test();
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Waits for hready high; q keeps the read data.
    task rdy();
        logic ok;
        do begin
            @(negedge clock) ok = hreadyout;
            q = hrdata;
            @(posedge clock);
        end while (ok !== 1'b1);
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
    endtask
    // Loads block, config, control; reads status into q.
    task run(input logic [31:0] ctl);
        init.build(f, lba, len, b1, c, tg, xl);
        for (int w = 0; w < 32; w += 4)
            bus(1'b1, 12'(w), {init.cdb[w + 3], init.cdb[w + 2], init.cdb[w + 1], init.cdb[w]});
        bus(1'b1, vcd_pkg::A_CONFIG, cfg);
        s0 = starts;
        bus(1'b1, vcd_pkg::A_CONTROL, ctl);
        bus(1'b0, vcd_pkg::A_STATUS, 32'h0);
    endtask
    function logic [31:0] expv(input int i);
        logic [31:0] e [7];
        e[0] = {5'h0, 3'(1 << f), 24'h1};
        e[1] = {18'h0, (f == 2'h2) ? 3'h7 : 3'h0, c[0], c[1], c[7:6], b1[2:1],
            b1[3] & (f == 2'h0), b1[4], b1[7:5]};
        e[2] = lba[31:0];
        e[3] = lba[63:32];
        e[4] = len;
        e[5] = tg[63:32];
        e[6] = {tg[15:0], tg[31:16]};
        return e[i];
    endfunction
    initial begin
        {srst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 68'h0, vcd_pkg::HSIZE_WORD};
        void'($urandom(94321));
        xl = vcd_pkg::ADD_LEN_32;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        for (int k = 0; k < 12; k++) begin
            r = $urandom;
            f = 2'(k % 3);
            lba = {(f == 2'h0) ? 32'h0 : $urandom, $urandom};
            {len, tg, c, cfg} = {$urandom | 32'h1, $urandom, $urandom, r[15:8] & 8'hC3, 32'h0};
            b1 = {3'h0, r[0], r[1] & (f != 2'h2), bcs[r[3:2] % 3], 1'b0};
            if (f == 2'h2) cfg = 32'h13;
            run(32'h1);
            for (int i = 0; i < ((f == 2'h2) ? 7 : 5); i++) begin
                if (i > 0) bus(1'b0, 12'(vcd_pkg::A_STATUS + 4 * i), 32'h0);
                chk(q, expv(i));
            end
            chk(32'(starts - s0), 32'h1);
        end
        {f, b1, cfg, len} = {2'h1, 8'h0, 32'h0, 32'h0};
        run(32'h1);
        chk({q[27], q[1], 30'(starts - s0)}, 32'h80000000);
        {f, len, tg} = {2'h2, 32'h3, 64'h12345678A5A500FF};
        for (int k = 0; k < 4; k++) begin
            t = pis[k];
            cfg = 32'(t[39:32]);
            bus(1'b1, vcd_pkg::A_PI_REF, 32'h12345678 ^ 32'(t[31:24]));
            bus(1'b1, vcd_pkg::A_PI_APP, {16'h1, t[23:8]});
            run(32'h2);
            chk(q, {3'h0, |t[7:0], 4'h4, t[7:0], (|t[7:0]) ? {vcd_pkg::ASC_PI_FAIL,
                vcd_pkg::SK_ABORTED, 4'h3} : 16'h1});
        end
        bus(1'b0, vcd_pkg::A_APP_TAG, 32'h0);
        chk(q, 32'h0);
        for (int k = 0; k < 7; k++) begin
            t = errs[k];
            {f, b1, cfg, xl, len} = {t[33:32], t[31:24], 32'(t[23:16]), t[15:8], 32'h5};
            run(32'h1);
            chk({q[15:0], 16'(starts - s0)}, {t[7:0], vcd_pkg::SK_ILLEGAL, 20'h30000});
        end
        bus(1'b0, 12'h100, 32'h0);
        chk(q, 32'h0);
        finish_test();
    end
endmodule // vcd_verify_decoder_tb
bind vcd_verify_decoder vcd_verify_decoder_asserts u_chk (.clock(clock), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .verify_start(verify_start));
